// [include/asl_pkg.sv]
/*
 * Shared constants for the axis status/latch/cause register bank:
 * register offsets, field positions, widths and pin indices.
 * Assumes a 32-bit plain register port with byte offsets.
 */
package asl_pkg;

    // widths
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned CNT_W    = 28;
    localparam int unsigned STATE_W  = 4;
    localparam int unsigned ERR_W    = 9;
    localparam int unsigned EVT_W    = 14;
    localparam int unsigned MOT_EV_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_LATCH_ONE  = 8'h00;
    localparam logic [7:0] OFS_LATCH_TWO  = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_ERR_CAUSE  = 8'h0C;
    localparam logic [7:0] OFS_EVT_CAUSE  = 8'h10;
    localparam logic [7:0] OFS_REMAINING  = 8'h14;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h18;

    // synchronised pin indices, in status bit order
    localparam int unsigned PIN_SLOWDOWN = 0;
    localparam int unsigned PIN_START    = 1;
    localparam int unsigned PIN_STOP     = 2;
    localparam int unsigned PIN_EMG      = 3;
    localparam int unsigned PIN_POS_TRIG = 4;
    localparam int unsigned PIN_DEV_CLR  = 5;
    localparam int unsigned PIN_INDEX    = 6;
    localparam int unsigned PIN_JOG_POS  = 7;
    localparam int unsigned PIN_JOG_NEG  = 8;
    localparam int unsigned PIN_LATCH    = 9;
    localparam int unsigned PIN_SD_TERM  = 10;
    localparam int unsigned PIN_INPOS    = 11;
    localparam int unsigned PIN_HOME     = 12;
    localparam int unsigned PIN_N        = 13;
    localparam int unsigned STS_PINS_N   = 12;

    // status layout
    localparam int unsigned STS_STATE_LSB = 0;
    localparam int unsigned STS_PIN_LSB   = 4;
    localparam int unsigned STS_DIR_BIT   = 16;

    // operation state codes
    localparam logic [3:0] ST_STOPPED    = 4'h0;
    localparam logic [3:0] ST_WAIT_JOG   = 4'h1;
    localparam logic [3:0] ST_WAIT_START = 4'h2;
    localparam logic [3:0] ST_WAIT_SYNC  = 4'h3;
    localparam logic [3:0] ST_WAIT_AXIS  = 4'h4;
    localparam logic [3:0] ST_WAIT_DEVCL = 4'h5;
    localparam logic [3:0] ST_WAIT_DIRCH = 4'h6;
    localparam logic [3:0] ST_WAIT_PULSR = 4'h8;
    localparam logic [3:0] ST_LOW_SPEED  = 4'hA;
    localparam logic [3:0] ST_ACCEL      = 4'hB;
    localparam logic [3:0] ST_HIGH_SPEED = 4'hC;
    localparam logic [3:0] ST_DECEL      = 4'hD;
    localparam logic [3:0] ST_WAIT_INPOS = 4'hE;
    localparam logic [3:0] ST_START_STOP = 4'hF;

    // error cause bits
    localparam int unsigned ERR_POS_LIMIT  = 0;
    localparam int unsigned ERR_NEG_LIMIT  = 1;
    localparam int unsigned ERR_ALARM      = 2;
    localparam int unsigned ERR_EXT_STOP   = 3;
    localparam int unsigned ERR_EMG        = 4;
    localparam int unsigned ERR_SLOWDOWN   = 5;
    localparam int unsigned ERR_PULSER_OVF = 6;
    localparam int unsigned ERR_ENCODER    = 7;
    localparam int unsigned ERR_PULSER     = 8;

    // event cause bits 0..7 come straight from the motion core
    localparam int unsigned EVT_LATCH_PIN = 8;
    localparam int unsigned EVT_HOME_PIN  = 9;
    localparam int unsigned EVT_SLOWDOWN  = 10;
    localparam int unsigned EVT_JOG_POS   = 11;
    localparam int unsigned EVT_JOG_NEG   = 12;
    localparam int unsigned EVT_START     = 13;

    // reset values
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

endpackage

// [include/asl_pin_if.sv]
/*
 * Carrier for synchronised axis pin levels between the pin
 * synchroniser and the register bank core. Single clock domain.
 */
`timescale 1ns/1ps
interface asl_pin_if #(
    parameter int unsigned W = 13
);
    logic [W-1:0] level;

    modport sync_side (output level);
    modport core_side (input level);
endinterface

// [hw/asl_pin_sync.sv]
/*
 * Two-stage synchroniser for the axis input pins.
 * Assumes pins are asynchronous to mclk_i; only stage two leaves here.
 */
`timescale 1ns/1ps
module asl_pin_sync
    import asl_pkg::*;
#(
    parameter int unsigned W = PIN_N
) (
    input  wire logic         mclk_i,   // reference clock
    input  wire logic         rstn_i,   // async reset, active low
    input  wire logic [W-1:0] pins_i,   // raw pin levels
    asl_pin_if.sync_side      pins_o    // synchronised levels
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } asl_sync_type;

    asl_sync_type state;
    asl_sync_type next_state;

    always_comb begin
        next_state        = state;
        next_state.stage1 = pins_i;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pins_o.level = state.stage2;

endmodule

// [hw/asl_status_regs.sv]
/*
 * Read-side register bank of one motion axis: two counter latches,
 * extended status, read-clear error and event cause registers,
 * remaining-pulse counter and the event enable register.
 * Assumes motion core signals are on mclk_i; axis pins are asynchronous.
 * Register port: one-cycle strobes, read data valid the cycle after.
 */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Behaviour
// - latch counter one on latch triggers
// - latch counter two likewise, signed 28-bit
// - state field codes stop and waits
// - state field codes motion phases
// - status bits 4-15 mirror input pins
// - status bit 16 gives direction
// - error interrupt sets matching error bit
// - cause registers clear when read
// - bits 0,1 limit switch stops
// - bit 2 alarm stop or alarm
// - bit 3 ext stop, bit 4 emergency; code also sets bit 4 on alarm_in_stop_i
// - bit 5 slowdown stop
// - bit 6 pulser buffer overflow
// - bits 7,8 encoder/pulser errors, no stop
// - event sets matching event bit
// - event bits 0-5 motion events
// - event bits 6,7 comparators
// - event bits 8,9 latch sources
// - event bits 10-13 input changes
// - positioning start loads absolute move amount
// - remaining count decrements per pulse
// - event only when enable bit set
// - simultaneous pulser change or overflow errors
module asl_status_regs
    import asl_pkg::*;
#(
    parameter int unsigned CW = CNT_W
) (
    input  wire logic                mclk_i,          // 40 MHz reference clock
    input  wire logic                rstn_i,          // async reset, active low
    // register port
    input  wire logic [ADDR_W-1:0]   addr_i,          // byte address
    input  wire logic [DATA_W-1:0]   wdata_i,         // write data
    input  wire logic                wr_i,            // write strobe
    input  wire logic                rd_i,            // read strobe
    output logic      [DATA_W-1:0]   rdata_o,         // read data, cycle after rd_i
    output logic                     event_irq_o,     // any event cause pending
    output logic                     error_irq_o,     // any error cause pending
    // axis pins, asynchronous
    input  wire logic [STS_PINS_N-1:0] axis_pins_i,   // status pins, status bit order
    input  wire logic                home_sensor_signal_i, // home sensor pin
    // motion core, same clock
    input  wire logic signed [CW-1:0] counter_one_i,  // general counter one
    input  wire logic signed [CW-1:0] counter_two_i,  // general counter two
    input  wire logic                latch_command_i, // latch command pulse
    input  wire logic [STATE_W-1:0]  operation_state_field_i, // sequencer state
    input  wire logic                direction_flag_i, // 1 = negative direction
    input  wire logic [MOT_EV_W-1:0] motion_event_i,  // event pulses, cause bits 0..7
    input  wire logic                stop_pos_limit_i, // stopped by positive limit
    input  wire logic                stop_neg_limit_i, // stopped by negative limit
    input  wire logic                stop_alarm_i,    // stopped by servo alarm
    input  wire logic                alarm_in_stop_i, // alarm while stopping
    input  wire logic                stop_ext_i,      // stopped by external stop
    input  wire logic                stop_emg_i,      // stopped by emergency stop
    input  wire logic                stop_slowdown_i, // slowed and stopped by slowdown
    input  wire logic                pulser_overflow_flag_i, // 4-bit buffer overflow
    input  wire logic                encoder_error_flag_i,   // encoder phase error
    input  wire logic                pulser_error_flag_i,    // other pulser error
    input  wire logic                pulser_mode_i,   // jog pins used as pulser
    input  wire logic                position_start_i, // positioning start pulse
    input  wire logic signed [CW-1:0] move_amount_setting_i, // signed move amount
    input  wire logic                pulse_out_i      // one output pulse issued
);

    ////////////////////////////////////////////////////////////////////////////
    // types and helpers

    typedef struct packed {
        logic signed [CW-1:0]   latch_one;
        logic signed [CW-1:0]   latch_two;
        logic [ERR_W-1:0]       err_cause;
        logic [EVT_W-1:0]       evt_cause;
        logic [EVT_W-1:0]       evt_enable;
        logic [CW-1:0]          remaining;
        logic [PIN_N-1:0]       pins_prev;
        logic [DATA_W-1:0]      rdata;
        logic                   evt_irq;
        logic                   err_irq;
    } asl_regs_type;

    // sign-extend a counter value to a bus word
    function automatic logic [DATA_W-1:0] sext(input logic signed [CW-1:0] v);
        sext = DATA_W'(signed'(v));
    endfunction

    // absolute value; the most negative input maps onto 2**(CW-1)
    function automatic logic [CW-1:0] magnitude(input logic signed [CW-1:0] v);
        magnitude = v[CW-1] ? CW'(-v) : CW'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    asl_pin_if #(.W(PIN_N)) pin_bus ();

    asl_pin_sync #(
        .W      (PIN_N)
    ) u_pin_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .pins_i ({home_sensor_signal_i, axis_pins_i}),
        .pins_o (pin_bus.sync_side)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    asl_regs_type state;
    asl_regs_type next_state;

    logic [PIN_N-1:0]  pin_lvl;
    logic [PIN_N-1:0]  pin_rise;
    logic [PIN_N-1:0]  pin_chg;
    logic              latch_fire;
    logic [ERR_W-1:0]  err_set;
    logic [EVT_W-1:0]  evt_raw;
    logic [EVT_W-1:0]  evt_set;
    logic [DATA_W-1:0] status_word;
    logic              rd_err;
    logic              rd_evt;

    assign pin_lvl = pin_bus.level;

    ////////////////////////////////////////////////////////////////////////////
    // event and error sources

    always_comb begin
        pin_rise   = pin_lvl & ~state.pins_prev;
        pin_chg    = pin_lvl ^ state.pins_prev;
        latch_fire = pin_rise[PIN_LATCH] | pin_rise[PIN_HOME] | latch_command_i;

        err_set                 = '0;
        err_set[ERR_POS_LIMIT]  = stop_pos_limit_i;
        err_set[ERR_NEG_LIMIT]  = stop_neg_limit_i;
        err_set[ERR_ALARM]      = stop_alarm_i | alarm_in_stop_i;
        err_set[ERR_EXT_STOP]   = stop_ext_i;
        err_set[ERR_EMG]        = stop_emg_i | alarm_in_stop_i;
        err_set[ERR_SLOWDOWN]   = stop_slowdown_i;
        err_set[ERR_PULSER_OVF] = pulser_overflow_flag_i;
        err_set[ERR_ENCODER]    = encoder_error_flag_i;
        // both pulser phases toggling together is a lost count
        err_set[ERR_PULSER]     = pulser_error_flag_i
                                | (pulser_mode_i & pin_chg[PIN_JOG_POS]
                                   & pin_chg[PIN_JOG_NEG]);

        evt_raw                      = '0;
        evt_raw[MOT_EV_W-1:0]        = motion_event_i;
        evt_raw[EVT_LATCH_PIN]       = pin_rise[PIN_LATCH];
        evt_raw[EVT_HOME_PIN]        = pin_rise[PIN_HOME];
        evt_raw[EVT_SLOWDOWN]        = pin_rise[PIN_SD_TERM];
        evt_raw[EVT_JOG_POS]         = pin_chg[PIN_JOG_POS];
        evt_raw[EVT_JOG_NEG]         = pin_chg[PIN_JOG_NEG];
        evt_raw[EVT_START]           = pin_rise[PIN_START];
        evt_set                      = evt_raw & state.evt_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // extended status word

    always_comb begin
        status_word = RST_WORD;
        status_word[STS_STATE_LSB +: STATE_W] = operation_state_field_i;
        status_word[STS_PIN_LSB +: STS_PINS_N] = pin_lvl[STS_PINS_N-1:0];
        status_word[STS_DIR_BIT] = direction_flag_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register update

    always_comb begin
        rd_err = rd_i && (addr_i == OFS_ERR_CAUSE);
        rd_evt = rd_i && (addr_i == OFS_EVT_CAUSE);

        next_state           = state;
        next_state.pins_prev = pin_lvl;

        if (latch_fire) begin
            next_state.latch_one = counter_one_i;
            next_state.latch_two = counter_two_i;
        end

        // a source firing in the clearing read's cycle survives the clear
        next_state.err_cause = (rd_err ? '0 : state.err_cause) | err_set;
        next_state.evt_cause = (rd_evt ? '0 : state.evt_cause) | evt_set;

        if (position_start_i) begin
            next_state.remaining = magnitude(move_amount_setting_i);
        end else if (pulse_out_i && (state.remaining != '0)) begin
            next_state.remaining = state.remaining - CW'(1);
        end

        if (wr_i && (addr_i == OFS_EVT_ENABLE)) begin
            next_state.evt_enable = wdata_i[EVT_W-1:0];
        end

        next_state.rdata = RST_WORD;
        if (rd_i) begin
            case (addr_i)
                OFS_LATCH_ONE:  next_state.rdata = sext(state.latch_one);
                OFS_LATCH_TWO:  next_state.rdata = sext(state.latch_two);
                OFS_STATUS:     next_state.rdata = status_word;
                OFS_ERR_CAUSE:  next_state.rdata = DATA_W'(state.err_cause);
                OFS_EVT_CAUSE:  next_state.rdata = DATA_W'(state.evt_cause);
                OFS_REMAINING:  next_state.rdata = DATA_W'(state.remaining);
                OFS_EVT_ENABLE: next_state.rdata = DATA_W'(state.evt_enable);
                default:        next_state.rdata = RST_WORD;
            endcase
        end

        next_state.evt_irq = |next_state.evt_cause;
        next_state.err_irq = |next_state.err_cause;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdata_o     = state.rdata;
    assign event_irq_o = state.evt_irq;
    assign error_irq_o = state.err_irq;

endmodule

// [tb/asl_status_regs_chk.sv]
/*
 * Concurrent checks on the register port of asl_status_regs.
 * Assumes single clock mclk_i and active-low asynchronous reset rstn_i.
 */
`timescale 1ns/1ps
module asl_status_regs_chk
    import asl_pkg::*;
#(
    parameter int unsigned CW = CNT_W
) (
    input  wire logic                  mclk_i,                // clock
    input  wire logic                  rstn_i,                // reset, active low
    input  wire logic [ADDR_W-1:0]     addr_i,                // byte address
    input  wire logic                  rd_i,                  // read strobe
    input  wire logic [DATA_W-1:0]     rdata_o,               // read data
    input  wire logic                  event_irq_o,           // event pending
    input  wire logic                  error_irq_o,           // error pending
    input  wire logic                  stop_pos_limit_i,      // positive limit stop
    input  wire logic                  direction_flag_i,      // direction
    input  wire logic                  latch_command_i,       // latch command
    input  wire logic signed [CW-1:0]  counter_one_i,         // counter one
    input  wire logic                  position_start_i,      // positioning start
    input  wire logic signed [CW-1:0]  move_amount_setting_i  // move amount
);
    logic [CW-1:0] mag;

    assign mag = move_amount_setting_i[CW-1] ? CW'(-move_amount_setting_i)
                                             : move_amount_setting_i;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    ////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data not zero outside a read");
    a_sts_upper: assert property (rd_i && addr_i == OFS_STATUS |=> rdata_o[31:17] == '0)
        else $error("status upper bits not zero");
    a_err_upper: assert property (rd_i && addr_i == OFS_ERR_CAUSE |=> rdata_o[31:9] == '0)
        else $error("error cause upper bits not zero");
    a_evt_upper: assert property (rd_i && addr_i == OFS_EVT_CAUSE |=> rdata_o[31:14] == '0)
        else $error("event cause upper bits not zero");
    a_dir_bit: assert property (rd_i && addr_i == OFS_STATUS && $stable(direction_flag_i)
        |=> rdata_o[STS_DIR_BIT] == $past(direction_flag_i))
        else $error("direction bit wrong");
    a_err_set: assert property (stop_pos_limit_i |=> error_irq_o)
        else $error("limit stop did not raise error");
    a_err_hold: assert property (error_irq_o && !(rd_i && addr_i == OFS_ERR_CAUSE)
        |=> error_irq_o)
        else $error("error cause lost without a read");
    a_evt_hold: assert property (event_irq_o && !(rd_i && addr_i == OFS_EVT_CAUSE)
        |=> event_irq_o)
        else $error("event cause lost without a read");
    a_latch_one: assert property (latch_command_i ##1 (rd_i && addr_i == OFS_LATCH_ONE)
        |=> rdata_o == 32'($past(counter_one_i, 2)))
        else $error("latch one does not hold commanded count");
    a_remain_load: assert property (position_start_i ##1 (rd_i && addr_i == OFS_REMAINING)
        |=> rdata_o == 32'($past(mag, 2)))
        else $error("remaining count not loaded with magnitude");
endmodule

bind asl_status_regs asl_status_regs_chk #(.CW(CW)) u_chk (
    .mclk_i, .rstn_i, .addr_i, .rd_i, .rdata_o, .event_irq_o, .error_irq_o,
    .stop_pos_limit_i, .direction_flag_i, .latch_command_i, .counter_one_i,
    .position_start_i, .move_amount_setting_i
);

// [tb/asl_status_regs_test.sv]
/*
 * Self-checking bench for asl_status_regs: status rows, cause registers,
 * latches and remaining count. Assumes the bench owns every input.
 */
`timescale 1ns/1ps
module asl_status_regs_test
    import asl_pkg::*;
;
    typedef struct packed {logic [3:0] st; logic dir; logic [11:0] pins; logic [31:0] sts;}
        asl_row_type;
    asl_row_type rows [14] = '{'{4'h0, 1'b0, 12'h001, 32'h0000_0010},
        '{4'h1, 1'b0, 12'h002, 32'h0000_0021}, '{4'h2, 1'b1, 12'h004, 32'h0001_0042},
        '{4'h3, 1'b0, 12'h008, 32'h0000_0083}, '{4'h4, 1'b0, 12'h010, 32'h0000_0104},
        '{4'h5, 1'b0, 12'h020, 32'h0000_0205}, '{4'h6, 1'b0, 12'h040, 32'h0000_0406},
        '{4'h8, 1'b0, 12'h080, 32'h0000_0808}, '{4'hA, 1'b0, 12'h100, 32'h0000_100A},
        '{4'hB, 1'b0, 12'h200, 32'h0000_200B}, '{4'hC, 1'b0, 12'h400, 32'h0000_400C},
        '{4'hD, 1'b0, 12'h800, 32'h0000_800D}, '{4'hE, 1'b1, 12'hFFF, 32'h0001_FFFE},
        '{4'hF, 1'b1, 12'h000, 32'h0001_000F}};
    logic [8:0] err_exp [10] = '{9'h001, 9'h002, 9'h004, 9'h014, 9'h008, 9'h010, 9'h020,
        9'h040, 9'h080, 9'h100};
    int pidx [6] = '{10, 1, 9, 12, 7, 8};
    int pbit [6] = '{10, 13, 8, 9, 11, 12};
    logic mclk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, latch_command_i = 1'b0;
    logic direction_flag_i = 1'b0, pulser_mode_i = 1'b0, position_start_i = 1'b0;
    logic pulse_out_i = 1'b0, event_irq_o, error_irq_o;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0, rdata_o;
    logic [12:0] pins = '0;
    logic [9:0] err_src = '0;
    logic [MOT_EV_W-1:0] motion_event_i = '0;
    logic [STATE_W-1:0] operation_state_field_i = '0;
    logic signed [CNT_W-1:0] counter_one_i = '0, counter_two_i = '0, move_amount_setting_i = '0;
    int mismatches = 0, n_tests = 0, cyc = 0;

    asl_status_regs dut (.mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .event_irq_o, .error_irq_o, .axis_pins_i(pins[11:0]), .home_sensor_signal_i(pins[12]),
        .counter_one_i, .counter_two_i, .latch_command_i, .operation_state_field_i,
        .direction_flag_i, .motion_event_i, .stop_pos_limit_i(err_src[0]),
        .stop_neg_limit_i(err_src[1]), .stop_alarm_i(err_src[2]), .alarm_in_stop_i(err_src[3]),
        .stop_ext_i(err_src[4]), .stop_emg_i(err_src[5]), .stop_slowdown_i(err_src[6]),
        .pulser_overflow_flag_i(err_src[7]), .encoder_error_flag_i(err_src[8]),
        .pulser_error_flag_i(err_src[9]), .pulser_mode_i, .position_start_i,
        .move_amount_setting_i, .pulse_out_i);

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read issued right after the current edge, data checked in its one valid cycle
    task automatic rd_now(input logic [7:0] a, input logic [31:0] exp);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk32(rdata_o, exp);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        rd_now(a, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        foreach (rows[i]) begin
            @(posedge mclk_i);
            operation_state_field_i <= rows[i].st;
            direction_flag_i <= rows[i].dir;
            pins[11:0] <= rows[i].pins;
            repeat (4) @(posedge mclk_i);
            rd(OFS_STATUS, rows[i].sts);
        end
        $display("status rows done");
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        pins <= '0;
        operation_state_field_i <= '0;
        direction_flag_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        for (int a = 0; a <= 28; a += 4) rd(8'(a), RST_WORD);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        wr(OFS_ERR_CAUSE, 32'hFFFF_FFFF);
        rd(OFS_STATUS, RST_WORD);
        rd(OFS_ERR_CAUSE, RST_WORD);
        $display("reset and read-only test done");
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_i);
            err_src <= 10'(1 << i);
            @(posedge mclk_i);
            err_src <= '0;
            #1 chk1(error_irq_o, 1'b1);
            rd(OFS_ERR_CAUSE, 32'(err_exp[i]));
            chk1(error_irq_o, 1'b0);
        end
        @(posedge mclk_i);
        err_src <= 10'h001;
        @(posedge mclk_i);
        err_src <= 10'h002;
        rd_now(OFS_ERR_CAUSE, 32'h0000_0001);
        err_src <= '0;
        rd(OFS_ERR_CAUSE, 32'h0000_0002);
        @(posedge mclk_i);
        pulser_mode_i <= 1'b1;
        pins[8:7] <= 2'b11;
        repeat (5) @(posedge mclk_i);
        rd(OFS_ERR_CAUSE, 32'h0000_0100);
        pulser_mode_i <= 1'b0;
        pins[8:7] <= 2'b00;
        repeat (5) @(posedge mclk_i);
        rd(OFS_ERR_CAUSE, RST_WORD);
        $display("error cause test done");
        wr(OFS_EVT_ENABLE, 32'hFFFF_FFFF);
        rd(OFS_EVT_ENABLE, 32'h0000_3FFF);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            motion_event_i <= 8'(1 << i);
            @(posedge mclk_i);
            motion_event_i <= '0;
            #1 chk1(event_irq_o, 1'b1);
            rd(OFS_EVT_CAUSE, 32'(1 << i));
            rd(OFS_EVT_CAUSE, RST_WORD);
        end
        counter_one_i <= -28'sd5;
        counter_two_i <= 28'sh7FF_FFFF;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk_i);
            pins[pidx[i]] <= 1'b1;
            repeat (5) @(posedge mclk_i);
            rd(OFS_EVT_CAUSE, 32'(1 << pbit[i]));
            pins[pidx[i]] <= 1'b0;
            repeat (5) @(posedge mclk_i);
            rd(OFS_EVT_CAUSE, (i > 3) ? 32'(1 << pbit[i]) : RST_WORD);
        end
        rd(OFS_LATCH_ONE, 32'hFFFF_FFFB);
        rd(OFS_LATCH_TWO, 32'h07FF_FFFF);
        wr(OFS_EVT_ENABLE, RST_WORD);
        counter_one_i <= 28'sh800_0000;
        counter_two_i <= 28'sd1;
        latch_command_i <= 1'b1;
        motion_event_i <= 8'hFF;
        @(posedge mclk_i);
        latch_command_i <= 1'b0;
        motion_event_i <= '0;
        counter_one_i <= '0;
        counter_two_i <= '0;
        rd_now(OFS_LATCH_ONE, 32'hF800_0000);
        rd(OFS_LATCH_TWO, 32'h0000_0001);
        rd(OFS_EVT_CAUSE, RST_WORD);
        $display("event and latch test done");
        move_amount_setting_i <= -28'sd3;
        position_start_i <= 1'b1;
        @(posedge mclk_i);
        position_start_i <= 1'b0;
        rd_now(OFS_REMAINING, 32'h0000_0003);
        pulse_out_i <= 1'b1;
        @(posedge mclk_i);
        pulse_out_i <= 1'b0;
        rd(OFS_REMAINING, 32'h0000_0002);
        pulse_out_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        pulse_out_i <= 1'b0;
        rd(OFS_REMAINING, RST_WORD);
        move_amount_setting_i <= 28'sh800_0000;
        position_start_i <= 1'b1;
        @(posedge mclk_i);
        position_start_i <= 1'b0;
        rd_now(OFS_REMAINING, 32'h0800_0000);
        $display("remaining count test done");
        final_report();
    end
endmodule
